// ==== logic/dcf_regs.vh ====
// Constants for the FIFO flag block: sizes, register map, fields, reset values, timing.
`ifndef DCF_REGS_VH
`define DCF_REGS_VH
`define DCF_DW 18
`define DCF_AW 6
`define DCF_CW 7
`define DCF_DEPTH 7'h40
`define DCF_HALF 7'h20
`define DCF_LAST 6'h3F
`define DCF_AF_LIMIT 8'h41
`define DCF_BUS_AW 8
`define DCF_OFS_AE_OFFSET 8'h00
`define DCF_OFS_AF_OFFSET 8'h04
`define DCF_OFS_STATUS 8'h08
`define DCF_OFS_IRQ_STAT 8'h0C
`define DCF_OFS_IRQ_MASK 8'h10
`define DCF_AE_OFFSET_RST 7'h08
`define DCF_AF_OFFSET_RST 7'h08
`define DCF_IRQ_W 5
`define DCF_IRQ_MASK_RST 5'h00
`define DCF_EV_WR_REFUSED 0
`define DCF_EV_RD_REFUSED 1
`define DCF_EV_ALMOST_FULL 2
`define DCF_EV_ALMOST_EMPTY 3
`define DCF_EV_RT_DONE 4
`define DCF_ST_CNT_LSB 0
`define DCF_ST_FLAG_LSB 8
`define DCF_ST_RT_BUSY 13
`define DCF_CLK_NS 50
`define DCF_RTR_NS 25
`define DCF_RTR_CYC ((`DCF_RTR_NS + `DCF_CLK_NS - 1) / `DCF_CLK_NS)
`define DCF_RESP_OKAY 2'h0
`define DCF_RESP_SLVERR 2'h2
`endif

// ==== logic/dcf_mem.v ====
// Storage array with a registered, resettable read port.
`timescale 1ns/100ps
`default_nettype none
`include "dcf_regs.vh"
module dcf_mem (
  // Clock and reset
  input  wire                aclk,
  input  wire                aresetn,
  // Write port
  input  wire                wr_en,
  input  wire [`DCF_AW-1:0]  wr_addr,
  input  wire [`DCF_DW-1:0]  wr_data,
  // Read port
  input  wire                rd_en,
  input  wire [`DCF_AW-1:0]  rd_addr,
  output reg  [`DCF_DW-1:0]  rd_data
);
  reg [`DCF_DW-1:0] mem [0:(1<<`DCF_AW)-1];

  always @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Output word clears on reset so the pins show zero until the first read.
  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_data <= {`DCF_DW{1'b0}};
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // dcf_mem
`default_nettype wire

// ==== logic/dcf_axil.v ====
// AXI4-Lite slave front end that turns bus beats into register strobes.
`timescale 1ns/100ps
`default_nettype none
`include "dcf_regs.vh"
module dcf_axil (
  // Clock and reset
  input  wire                   aclk,
  input  wire                   aresetn,
  // Write address and data
  input  wire [`DCF_BUS_AW-1:0] s_axi_awaddr,
  input  wire                   s_axi_awvalid,
  output wire                   s_axi_awready,
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output wire                   s_axi_wready,
  // Write response
  output reg  [1:0]             s_axi_bresp,
  output reg                    s_axi_bvalid,
  input  wire                   s_axi_bready,
  // Read address and data
  input  wire [`DCF_BUS_AW-1:0] s_axi_araddr,
  input  wire                   s_axi_arvalid,
  output wire                   s_axi_arready,
  output reg  [31:0]            s_axi_rdata,
  output reg  [1:0]             s_axi_rresp,
  output reg                    s_axi_rvalid,
  input  wire                   s_axi_rready,
  // Register side
  output wire                   reg_wr,
  output reg  [`DCF_BUS_AW-1:0] reg_waddr,
  output reg  [31:0]            reg_wdata,
  output reg  [3:0]             reg_wstrb,
  input  wire                   reg_wr_ok,
  output wire [`DCF_BUS_AW-1:0] reg_raddr,
  input  wire [31:0]            reg_rdata,
  input  wire                   reg_rd_ok
);
  reg aw_full_reg;
  reg w_full_reg;

  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
  assign reg_wr        = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign reg_raddr     = s_axi_araddr;

  // Address and data may arrive in either order; the write fires once both are held.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg  <= 1'b0;
      w_full_reg   <= 1'b0;
      reg_waddr    <= {`DCF_BUS_AW{1'b0}};
      reg_wdata    <= 32'h0;
      reg_wstrb    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DCF_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        reg_waddr   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        reg_wdata  <= s_axi_wdata;
        reg_wstrb  <= s_axi_wstrb;
      end
      if (reg_wr) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= reg_wr_ok ? `DCF_RESP_OKAY : `DCF_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `DCF_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= reg_rd_ok ? reg_rdata : 32'h0;
      s_axi_rresp  <= reg_rd_ok ? `DCF_RESP_OKAY : `DCF_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // dcf_axil
`default_nettype wire

// ==== logic/dcf_fifo.v ====
// FIFO with full, empty, half-full and programmable almost flags, retransmit and expansion.
//
// Functional notes
// - Full clears on the current read edge.
// - Empty clears on the current write edge.
// - Reset works with the clock running.
// - After reset, outputs low when driven.
// - First word readable cycle after empty clears.
// - First-read latency bounded at empty boundary.
// - Almost-empty low means below offset n.
// - Synchronous almost flags only when select low.
// - Almost-empty changes on current read edge.
// - Almost-full threshold is depth minus m plus one.
// - Almost-full low holds depth minus (m-1).
// - Almost-full changes on current write edge.
// - Write expansion pulses at last location.
// - Read expansion pulses at last location.
// - Flags valid after retransmit recovery.
// - Synchronous almost flags need one further cycle.
`timescale 1ns/100ps
`default_nettype none
`include "dcf_regs.vh"
module dcf_fifo (
  // Clock and reset
  input  wire                   aclk,
  input  wire                   aresetn,
  // Write side
  input  wire                   wr_en_n,
  input  wire [`DCF_DW-1:0]     wr_data,
  // Read side
  input  wire                   rd_en_n,
  input  wire                   out_en_n,
  output wire [`DCF_DW-1:0]     rd_data,
  output wire                   rd_data_oe,
  // Control
  input  wire                   retransmit_n,
  input  wire                   flag_sync_select,
  // Status flags
  output reg                    full_flag_n,
  output reg                    empty_flag_n,
  output reg                    half_full_flag_n,
  output reg                    almost_empty_flag_n,
  output reg                    almost_full_flag_n,
  // Expansion
  output reg                    write_expansion_out,
  output reg                    read_expansion_out,
  // Interrupt
  output wire                   irq,
  // AXI4-Lite write channels
  input  wire [`DCF_BUS_AW-1:0] s_axi_awaddr,
  input  wire                   s_axi_awvalid,
  output wire                   s_axi_awready,
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output wire                   s_axi_wready,
  output wire [1:0]             s_axi_bresp,
  output wire                   s_axi_bvalid,
  input  wire                   s_axi_bready,
  // AXI4-Lite read channels
  input  wire [`DCF_BUS_AW-1:0] s_axi_araddr,
  input  wire                   s_axi_arvalid,
  output wire                   s_axi_arready,
  output wire [31:0]            s_axi_rdata,
  output wire [1:0]             s_axi_rresp,
  output wire                   s_axi_rvalid,
  input  wire                   s_axi_rready
);
  // Recovery cycles, rounded up; the two-bit counter keeps only the low two bits of it.
  localparam integer RTR_CYC_INT = `DCF_RTR_CYC;
  localparam [1:0]   RTR_CYC     = RTR_CYC_INT[1:0];

  // Pointers, fill count and retransmit state.
  reg  [`DCF_AW-1:0]    wr_ptr_reg;
  reg  [`DCF_AW-1:0]    rd_ptr_reg;
  reg  [`DCF_CW-1:0]    cnt_reg;
  reg  [`DCF_CW-1:0]    cnt_next;
  reg                   rt_busy_reg;
  reg  [1:0]            rt_cnt_reg;
  // Software registers.
  reg  [`DCF_CW-1:0]    ae_offset_reg;
  reg  [`DCF_CW-1:0]    af_offset_reg;
  reg  [`DCF_IRQ_W-1:0] irq_stat_reg;
  reg  [`DCF_IRQ_W-1:0] irq_stat_next;
  reg  [`DCF_IRQ_W-1:0] irq_mask_reg;
  reg  [`DCF_IRQ_W-1:0] irq_ev;
  reg  [31:0]           reg_rdata;
  wire                  reg_wr;
  wire [`DCF_BUS_AW-1:0] reg_waddr;
  wire [31:0]           reg_wdata;
  wire [3:0]            reg_wstrb;
  wire [`DCF_BUS_AW-1:0] reg_raddr;
  wire                  wr_acc;
  wire                  rd_acc;
  wire                  rt_start;
  wire                  rt_done;
  wire [`DCF_CW-1:0]    rt_base;
  wire [`DCF_CW-1:0]    almost_src;
  wire                  ae_hit_now;
  wire                  af_hit_now;

  // True when the byte address names one of the mapped registers.
  function addr_hit;
    input [`DCF_BUS_AW-1:0] a;
    begin
      addr_hit = (a == `DCF_OFS_AE_OFFSET) || (a == `DCF_OFS_AF_OFFSET) ||
                 (a == `DCF_OFS_STATUS) || (a == `DCF_OFS_IRQ_STAT) ||
                 (a == `DCF_OFS_IRQ_MASK);
    end
  endfunction

  // Almost-empty while fewer than n words remain.
  function ae_hit;
    input [`DCF_CW-1:0] c;
    input [`DCF_CW-1:0] n;
    begin
      ae_hit = (c < n);
    end
  endfunction

  // Almost-full once depth - m + 1 words are held.
  function af_hit;
    input [`DCF_CW-1:0] c;
    input [`DCF_CW-1:0] m;
    begin
      af_hit = ({1'b0, c} + {1'b0, m}) >= `DCF_AF_LIMIT;
    end
  endfunction

  // True at the last physical location.
  function at_last;
    input [`DCF_AW-1:0] p;
    begin
      at_last = (p == `DCF_LAST);
    end
  endfunction

  // Handshakes are gated by the registered flags, so a refused beat never moves a pointer.
  assign wr_acc   = !wr_en_n && full_flag_n;
  // Retransmit held low restarts the replay after each recovery.
  assign rt_start = !retransmit_n && !rt_busy_reg;
  assign rd_acc   = !rd_en_n && empty_flag_n && !rt_busy_reg && retransmit_n;
  assign rt_done  = rt_busy_reg && (rt_cnt_reg == RTR_CYC);

  // Retransmit replays from location zero; a full wrapped array keeps its full count.
  assign rt_base = ((cnt_reg == `DCF_DEPTH) && (wr_ptr_reg == {`DCF_AW{1'b0}})) ?
                   `DCF_DEPTH : {1'b0, wr_ptr_reg};

  // A write on the replay edge still counts.
  always @* begin
    if (rt_start) begin
      cnt_next = rt_base + {{(`DCF_CW-1){1'b0}}, wr_acc};
    end else begin
      cnt_next = cnt_reg + {{(`DCF_CW-1){1'b0}}, wr_acc} - {{(`DCF_CW-1){1'b0}}, rd_acc};
    end
  end

  // The read port moves only on a taken read.
  dcf_mem u_mem (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_acc),
    .wr_addr (wr_ptr_reg),
    .wr_data (wr_data),
    .rd_en   (rd_acc),
    .rd_addr (rd_ptr_reg),
    .rd_data (rd_data)
  );

  // Data pins are driven while the output enable is low; the register holds zero after reset.
  assign rd_data_oe = !out_en_n;

  // Reset is synchronous and needs no stopped clock on either side.
  always @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_reg  <= {`DCF_AW{1'b0}};
      rd_ptr_reg  <= {`DCF_AW{1'b0}};
      cnt_reg     <= {`DCF_CW{1'b0}};
      rt_busy_reg <= 1'b0;
      rt_cnt_reg  <= 2'h0;
    end else begin
      cnt_reg <= cnt_next;
      if (wr_acc) begin
        wr_ptr_reg <= wr_ptr_reg + 6'h01;
      end
      if (rt_start) begin
        rd_ptr_reg  <= {`DCF_AW{1'b0}};
        rt_busy_reg <= 1'b1;
        rt_cnt_reg  <= 2'h1;
      end else if (rd_acc) begin
        rd_ptr_reg <= rd_ptr_reg + 6'h01;
      end
      // Reads stay refused until the recovery interval has run out.
      if (rt_done) begin
        rt_busy_reg <= 1'b0;
        rt_cnt_reg  <= 2'h0;
      end else if (rt_busy_reg) begin
        rt_cnt_reg <= rt_cnt_reg + 2'h1;
      end
    end
  end

  // One clock serves both ports, so every edge meets the skew needed for a same-edge change.
  // In synchronous mode the almost flags look at the settled count, one edge later.
  assign almost_src = flag_sync_select ? cnt_next : cnt_reg;
  assign ae_hit_now = ae_hit(almost_src, ae_offset_reg);
  assign af_hit_now = af_hit(almost_src, af_offset_reg);

  always @(posedge aclk) begin
    if (!aresetn) begin
      // Empty and almost-empty assert in reset.
      full_flag_n         <= 1'b1;
      empty_flag_n        <= 1'b0;
      half_full_flag_n    <= 1'b1;
      almost_empty_flag_n <= 1'b0;
      almost_full_flag_n  <= 1'b1;
      write_expansion_out <= 1'b0;
      read_expansion_out  <= 1'b0;
    end else begin
      full_flag_n         <= (cnt_next != `DCF_DEPTH);
      empty_flag_n        <= (cnt_next != {`DCF_CW{1'b0}});
      half_full_flag_n    <= !(cnt_next > `DCF_HALF);
      almost_empty_flag_n <= !ae_hit_now;
      almost_full_flag_n  <= !af_hit_now;
      write_expansion_out <= wr_acc && at_last(wr_ptr_reg);
      read_expansion_out  <= rd_acc && at_last(rd_ptr_reg);
    end
  end

  // Interrupt events are single-cycle causes sampled against the flag edges.
  always @* begin
    irq_ev = {`DCF_IRQ_W{1'b0}};
    irq_ev[`DCF_EV_WR_REFUSED]   = !wr_en_n && !full_flag_n;
    irq_ev[`DCF_EV_RD_REFUSED]   = !rd_en_n && !empty_flag_n;
    irq_ev[`DCF_EV_ALMOST_FULL]  = af_hit_now && almost_full_flag_n;
    irq_ev[`DCF_EV_ALMOST_EMPTY] = ae_hit_now && almost_empty_flag_n;
    irq_ev[`DCF_EV_RT_DONE]      = rt_done;
  end

  // A new event in the same cycle as a write-one clear keeps its bit set.
  always @* begin
    irq_stat_next = irq_stat_reg;
    if (reg_wr && (reg_waddr == `DCF_OFS_IRQ_STAT) && reg_wstrb[0]) begin
      irq_stat_next = irq_stat_reg & ~reg_wdata[`DCF_IRQ_W-1:0];
    end
    irq_stat_next = irq_stat_next | irq_ev;
  end

  // Offsets are seven bits so either can reach the full depth.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ae_offset_reg <= `DCF_AE_OFFSET_RST;
      af_offset_reg <= `DCF_AF_OFFSET_RST;
      irq_mask_reg  <= `DCF_IRQ_MASK_RST;
      irq_stat_reg  <= {`DCF_IRQ_W{1'b0}};
    end else begin
      irq_stat_reg <= irq_stat_next;
      if (reg_wr && reg_wstrb[0]) begin
        case (reg_waddr)
          `DCF_OFS_AE_OFFSET: begin
            ae_offset_reg <= reg_wdata[`DCF_CW-1:0];
          end
          `DCF_OFS_AF_OFFSET: begin
            af_offset_reg <= reg_wdata[`DCF_CW-1:0];
          end
          `DCF_OFS_IRQ_MASK: begin
            irq_mask_reg <= reg_wdata[`DCF_IRQ_W-1:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Level output: software clears each unmasked cause to drop it.
  assign irq = |(irq_stat_reg & irq_mask_reg);

  always @* begin
    reg_rdata = 32'h0;
    case (reg_raddr)
      `DCF_OFS_AE_OFFSET: begin
        reg_rdata[`DCF_CW-1:0] = ae_offset_reg;
      end
      `DCF_OFS_AF_OFFSET: begin
        reg_rdata[`DCF_CW-1:0] = af_offset_reg;
      end
      // Count, five flag levels and the replay busy bit.
      `DCF_OFS_STATUS: begin
        reg_rdata[`DCF_ST_CNT_LSB +: `DCF_CW] = cnt_reg;
        reg_rdata[`DCF_ST_FLAG_LSB +: 5]      = {almost_full_flag_n, almost_empty_flag_n,
                                                 half_full_flag_n, empty_flag_n,
                                                 full_flag_n};
        reg_rdata[`DCF_ST_RT_BUSY]            = rt_busy_reg;
      end
      `DCF_OFS_IRQ_STAT: begin
        reg_rdata[`DCF_IRQ_W-1:0] = irq_stat_reg;
      end
      `DCF_OFS_IRQ_MASK: begin
        reg_rdata[`DCF_IRQ_W-1:0] = irq_mask_reg;
      end
      default: begin
        reg_rdata = 32'h0;
      end
    endcase
  end

  // Unmapped addresses get an error response and change nothing.
  dcf_axil u_axil (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .reg_wr        (reg_wr),
    .reg_waddr     (reg_waddr),
    .reg_wdata     (reg_wdata),
    .reg_wstrb     (reg_wstrb),
    .reg_wr_ok     (addr_hit(reg_waddr)),
    .reg_raddr     (reg_raddr),
    .reg_rdata     (reg_rdata),
    .reg_rd_ok     (addr_hit(reg_raddr))
  );
endmodule // dcf_fifo
`default_nettype wire

// ==== tb/dcf_fifo_asserts.sv ====
// Checker of flag, data and expansion timing at the FIFO ports.
`timescale 1ns/100ps
`default_nettype none
`include "dcf_regs.vh"
module dcf_fifo_chk (
  // Clock and reset
  input wire logic               aclk,
  input wire logic               aresetn,
  // Data side
  input wire logic               wr_en_n,
  input wire logic [`DCF_DW-1:0] wr_data,
  input wire logic               rd_en_n,
  input wire logic               out_en_n,
  input wire logic [`DCF_DW-1:0] rd_data,
  input wire logic               rd_data_oe,
  input wire logic               retransmit_n,
  // Flags and expansion
  input wire logic               full_flag_n,
  input wire logic               empty_flag_n,
  input wire logic               almost_empty_flag_n,
  input wire logic               almost_full_flag_n,
  input wire logic               write_expansion_out,
  input wire logic               read_expansion_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_empty;
    !empty_flag_n && !wr_en_n && retransmit_n;
  endsequence
  sequence s_rd_next;
    !rd_en_n && empty_flag_n && retransmit_n;
  endsequence
  chk_first_word:
    assert property (s_wr_empty ##1 s_rd_next |=> rd_data == $past(wr_data, 2))
    else $error("first word after empty differs from the written word");
  chk_empty_clears:
    assert property (s_wr_empty |=> empty_flag_n)
    else $error("empty flag stayed low after a write");
  chk_full_clears:
    assert property (!full_flag_n && !rd_en_n && wr_en_n && retransmit_n
                     && $past(retransmit_n) |=> full_flag_n)
    else $error("full flag stayed low after a read");
  chk_full_ignored:
    assert property (!full_flag_n && rd_en_n && retransmit_n |=> !full_flag_n)
    else $error("full flag left without a read");
  chk_empty_ignored:
    assert property (!empty_flag_n && wr_en_n && retransmit_n |=> !empty_flag_n)
    else $error("empty flag left without a write");
  chk_wr_exp_pulse:
    assert property ($rose(write_expansion_out) |-> $past(!wr_en_n && full_flag_n)
                     ##1 !write_expansion_out)
    else $error("write expansion pulse without a write or too long");
  chk_rd_exp_cause:
    assert property (read_expansion_out |-> $past(!rd_en_n && empty_flag_n))
    else $error("read expansion pulse without a read");
  chk_oe_follow:
    assert property (rd_data_oe == !out_en_n)
    else $error("output enable does not follow its input");
  chk_reset_state:
    assert property (disable iff (1'b0) !aresetn |=> rd_data == '0 && !empty_flag_n
                     && full_flag_n && !almost_empty_flag_n && almost_full_flag_n)
    else $error("state after reset is wrong");
endmodule // dcf_fifo_chk
bind dcf_fifo dcf_fifo_chk i_chk (
  .aclk(aclk), .aresetn(aresetn), .wr_en_n(wr_en_n), .wr_data(wr_data),
  .rd_en_n(rd_en_n), .out_en_n(out_en_n), .rd_data(rd_data), .rd_data_oe(rd_data_oe),
  .retransmit_n(retransmit_n), .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
  .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n),
  .write_expansion_out(write_expansion_out), .read_expansion_out(read_expansion_out));
`default_nettype wire

// ==== tb/dcf_stream_model.sv ====
// Producer and consumer standing on the FIFO's write and read sides.
`timescale 1ns/100ps
`default_nettype none
`include "dcf_regs.vh"
module dcf_stream_model (
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // Bench commands and the FIFO full flag
  input  wire logic               wr_go,
  input  wire logic               rd_go,
  input  wire logic               full_flag_n,
  // FIFO side
  output wire logic               wr_en_n,
  output wire logic [`DCF_DW-1:0] wr_data,
  output wire logic               rd_en_n
);
  logic [`DCF_DW-1:0] seq_reg;
  // Idle data shows the inverse, so a stale word is never taken for a fresh one.
  assign wr_en_n = !wr_go;
  assign wr_data = wr_go ? seq_reg : ~seq_reg;
  assign rd_en_n = !rd_go;
  always @(posedge aclk) begin
    if (!aresetn) begin
      seq_reg <= '0;
    end else if (wr_go && full_flag_n) begin
      seq_reg <= seq_reg + 1'b1;
    end
  end
endmodule // dcf_stream_model
`default_nettype wire

// ==== tb/dcf_fifo_tb_top.sv ====
// Self-checking bench for the FIFO flag block.
`timescale 1ns/100ps
`default_nettype none
`include "dcf_regs.vh"
module dcf_fifo_tb_top;
  logic                    aclk = 1'b0;
  logic                    aresetn = 1'b0;
  logic                    wr_go = 1'b0, rd_go = 1'b0, out_en_n = 1'b0;
  logic                    retransmit_n = 1'b1, flag_sync_select = 1'b1;
  logic [7:0]              s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]             s_axi_wdata = 32'h0;
  logic                    s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                    s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire                     wr_en_n, rd_en_n, rd_data_oe, irq;
  wire [`DCF_DW-1:0]       wr_data, rd_data;
  wire                     full_flag_n, empty_flag_n, half_full_flag_n;
  wire                     almost_empty_flag_n, almost_full_flag_n;
  wire                     write_expansion_out, read_expansion_out;
  wire                     s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire                     s_axi_rvalid;
  wire [1:0]               s_axi_bresp, s_axi_rresp;
  wire [31:0]              s_axi_rdata;
  int                      n_fail = 0, n_tests = 0;

  always #25 aclk = ~aclk;

  dcf_stream_model i_model (.aclk(aclk), .aresetn(aresetn), .wr_go(wr_go), .rd_go(rd_go),
    .full_flag_n(full_flag_n), .wr_en_n(wr_en_n), .wr_data(wr_data), .rd_en_n(rd_en_n));

  dcf_fifo i_dut (.aclk(aclk), .aresetn(aresetn), .wr_en_n(wr_en_n), .wr_data(wr_data),
    .rd_en_n(rd_en_n), .out_en_n(out_en_n), .rd_data(rd_data), .rd_data_oe(rd_data_oe),
    .retransmit_n(retransmit_n), .flag_sync_select(flag_sync_select),
    .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
    .half_full_flag_n(half_full_flag_n), .almost_empty_flag_n(almost_empty_flag_n),
    .almost_full_flag_n(almost_full_flag_n), .write_expansion_out(write_expansion_out),
    .read_expansion_out(read_expansion_out), .irq(irq), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic hang;
    n_fail++;
    $display("Error bus handshake expected 1 seen 0");
    end_sim();
  endtask

  // Inputs for the next edge are set here; outputs of this edge are settled on return.
  task automatic tick(input logic w, input logic r);
    @(posedge aclk);
    wr_go <= w;
    rd_go <= r;
    #1;
  endtask

  task automatic chk_flags(input int c);
    chk("empty", c != 0, empty_flag_n);
    chk("full", c != `DCF_DEPTH, full_flag_n);
    chk("half", c <= `DCF_HALF, half_full_flag_n);
    chk("almost_empty", c >= `DCF_AE_OFFSET_RST, almost_empty_flag_n);
    chk("almost_full", c < `DCF_DEPTH - `DCF_AF_OFFSET_RST + 1, almost_full_flag_n);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (i == 20) hang();
    chk("bresp", `DCF_RESP_OKAY, s_axi_bresp);
    #1;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (i == 20) hang();
    chk("rdata", d, s_axi_rdata);
    chk("rresp", r, s_axi_rresp);
    #1;
  endtask

  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    wr_go <= 1'b0;
    rd_go <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
  endtask

  task automatic t_reset;
    do_reset();
    chk_flags(0);
    chk("rd_data", 0, rd_data);
    chk("oe", 1, rd_data_oe);
    @(posedge aclk);
    out_en_n <= 1'b1;
    #1 chk("oe", 0, rd_data_oe);
    @(posedge aclk);
    out_en_n <= 1'b0;
    axi_rd(`DCF_OFS_STATUS, 32'h1500, `DCF_RESP_OKAY);
    axi_rd(`DCF_OFS_AE_OFFSET, 32'h8, `DCF_RESP_OKAY);
    axi_rd(8'h14, 32'h0, `DCF_RESP_SLVERR);
  endtask

  task automatic t_first_word;
    do_reset();
    tick(0, 1);
    tick(0, 0);
    chk_flags(0);
    chk("irq", 0, irq);
    axi_wr(`DCF_OFS_IRQ_MASK, 32'h2);
    chk("irq", 1, irq);
    axi_wr(`DCF_OFS_IRQ_STAT, 32'h2);
    chk("irq", 0, irq);
    tick(1, 0);
    tick(0, 1);
    chk_flags(1);
    tick(0, 0);
    chk("rd_data", 0, rd_data);
    chk_flags(0);
    tick(1, 0);
    tick(0, 1);
    tick(0, 0);
    chk("rd_data", 1, rd_data);
  endtask

  task automatic t_fill;
    do_reset();
    tick(1, 0);
    // The last pass tries one write too many while full.
    for (int k = 1; k <= 65; k++) begin
      tick(k < 65, 0);
      chk_flags(k > 64 ? 64 : k);
      chk("wr_exp", k == 64, write_expansion_out);
    end
    tick(0, 1);
    for (int j = 0; j < 64; j++) begin
      tick(0, j < 63);
      chk("rd_data", j, rd_data);
      chk_flags(63 - j);
      chk("rd_exp", j == 63, read_expansion_out);
    end
  endtask

  task automatic t_sync;
    do_reset();
    @(posedge aclk);
    flag_sync_select <= 1'b0;
    tick(1, 0);
    repeat (7) tick(1, 0);
    tick(0, 0);
    chk("almost_empty", 0, almost_empty_flag_n);
    tick(0, 0);
    chk("almost_empty", 1, almost_empty_flag_n);
    @(posedge aclk);
    flag_sync_select <= 1'b1;
  endtask

  task automatic t_retransmit;
    do_reset();
    repeat (4) tick(1, 0);
    tick(0, 1);
    tick(0, 1);
    tick(0, 0);
    chk("rd_data", 1, rd_data);
    @(posedge aclk);
    retransmit_n <= 1'b0;
    @(posedge aclk);
    retransmit_n <= 1'b1;
    tick(0, 1);
    chk_flags(4);
    for (int j = 0; j < 4; j++) begin
      tick(0, j < 3);
      chk("rd_data", j, rd_data);
    end
  endtask

  initial begin
    t_reset();
    t_first_word();
    t_fill();
    t_sync();
    t_retransmit();
    end_sim();
  end
endmodule // dcf_fifo_tb_top
`default_nettype wire
